// >>> ppmx_checker.sv
// Checker: port timing of the pixel port multiplexer.
// Assumes a bind to ppmx_top and the constants header on the path.
`timescale 1ns/1ps
`include "ppmx_consts.svh"
module ppmx_checker
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] palette_addr,
  input wire ppmx_pkg::ppmx_kind_t pixel_kind,
  input wire logic pixel_valid,
  input wire logic [1:0] osc_select
);
  import ppmx_pkg::*;
  logic [1:0] osc_q;
  // ****************
  // Oscillator shadow
  // ****************
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      osc_q <= 2'h0;
    else if (reg_wr && reg_addr == `PPMX_ADDR_MUX_CTRL
             && reg_wdata[5:0] == `PPMX_MUX_PASS)
      osc_q <= 2'h0;
    else if (reg_wr && reg_addr == `PPMX_ADDR_CLK_SEL)
      osc_q <= reg_wdata[1:0];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ****************
  // Assertions
  // ****************
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_valid_pulse: assert property (pixel_valid |=> !pixel_valid)
    else $error("pixel valid longer than one cycle");
  a_hold_pixel: assert property (!pixel_valid
    |-> $stable(palette_addr) && $stable(pixel_kind))
    else $error("pixel output changed without valid");
  a_rst_pass: assert property ($rose(rst_b)
    |-> pixel_kind == PPMX_KIND_VGA)
    else $error("not in pass-through after reset");
  a_pass_clksel: assert property (reg_wr
    && reg_addr == `PPMX_ADDR_MUX_CTRL
    && reg_wdata[5:0] == `PPMX_MUX_PASS
    ##1 reg_rd && reg_addr == `PPMX_ADDR_CLK_SEL
    |=> reg_rdata == `PPMX_RST_CLK_SEL)
    else $error("clock select not restored");
  a_pass_mask: assert property (reg_wr
    && reg_addr == `PPMX_ADDR_MUX_CTRL
    && reg_wdata[5:0] == `PPMX_MUX_PASS ##1 !reg_wr
    ##1 reg_rd && reg_addr == `PPMX_ADDR_READ_MASK
    |=> reg_rdata == `PPMX_RST_READ_MASK)
    else $error("read mask not restored");
  a_pass_osc: assert property (pixel_valid
    && pixel_kind == PPMX_KIND_VGA |-> osc_select == 2'h0)
    else $error("pass-through not on oscillator zero");
  a_osc_norm: assert property (pixel_valid
    && pixel_kind != PPMX_KIND_VGA |-> osc_select == osc_q)
    else $error("oscillator differs from clock select");
endmodule
bind ppmx_top ppmx_checker u_chk (.clk, .rst_b, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .palette_addr,
  .pixel_kind, .pixel_valid, .osc_select);

// >>> ppmx_consts.svh
// Constants for the pixel port multiplexer.
// Assumes inclusion by the package, the top module, the checker and the testbench.
`ifndef PPMX_CONSTS_SVH
`define PPMX_CONSTS_SVH
// ******************************
// Register offsets
// ******************************
`define PPMX_ADDR_MUX_CTRL 4'h0
`define PPMX_ADDR_CLK_SEL 4'h1
`define PPMX_ADDR_GEN_CTRL 4'h2
`define PPMX_ADDR_READ_MASK 4'h3
`define PPMX_ADDR_PAL_PAGE 4'h4
`define PPMX_ADDR_STATUS 4'h5
// ******************************
// Reset values
// ******************************
`define PPMX_RST_MUX_CTRL 8'h2D
`define PPMX_RST_CLK_SEL 8'h00
`define PPMX_RST_GEN_CTRL 8'h00
`define PPMX_RST_READ_MASK 8'hFF
`define PPMX_RST_PAL_PAGE 8'h00
// ******************************
// Field positions and codes
// ******************************
`define PPMX_MUX_CODE_W 6
`define PPMX_MUX_PASS 6'h2D
`define PPMX_MUX_NIBBLE 6'h1F
`define PPMX_GC_SSRT 2
`define PPMX_GC_SNM 3
`define PPMX_CS_OSC_LSB 0
`define PPMX_CS_SHIFT_LSB 3
`endif

// >>> ppmx_pkg.sv
// Types for the pixel port multiplexer.
// Assumes the constants header is available on the include path.
`include "ppmx_consts.svh"
package ppmx_pkg;
  typedef enum logic [2:0]
  {
    PPMX_IDLE = 3'b001,
    PPMX_SHIFT = 3'b010,
    PPMX_PEND = 3'b100
  } ppmx_state_t;
  typedef enum logic [1:0]
  {
    PPMX_KIND_PAL = 2'h0,
    PPMX_KIND_VGA = 2'h1,
    PPMX_KIND_TRUE = 2'h2
  } ppmx_kind_t;
endpackage

// >>> ppmx_src.sv
// Source model: video memory loads with shift and dot clocks.
// Assumes start pulses only while busy is low.
`timescale 1ns/1ps
module ppmx_src
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [31:0] word,
  input wire logic [3:0] ngrp,
  output logic [31:0] pixel_port_lines,
  output logic [7:0] vga_port_lines,
  output logic shift_clock,
  output logic dot_rate_clock,
  output logic busy
);
  int t;
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      {pixel_port_lines, vga_port_lines} <= 40'h0;
      {shift_clock, dot_rate_clock, busy} <= 3'h0;
      t <= 0;
    end
    else if (!busy)
    begin
      pixel_port_lines <= word;
      vga_port_lines <= word[15:8];
      busy <= start;
      t <= 0;
    end
    else
    begin
      t <= t + 1;
      shift_clock <= t >= 2 && t < 8;
      // Hold time over, lines drift
      if (t == 9)
        {pixel_port_lines, vga_port_lines} <=
          ~{pixel_port_lines, vga_port_lines};
      dot_rate_clock <= t >= 10 && t < 10 + 8 * ngrp && t % 8 < 6;
      if (t == 18 + 8 * ngrp)
        busy <= 1'h0;
    end
endmodule

// >>> ppmx_top.sv
// Pixel port multiplexer: captures bus loads and serialises pixels.
// Assumes dot enable and shift clock arrive as pins, synchronised here.
`timescale 1ns/1ps
`include "ppmx_consts.svh"
module ppmx_top
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [31:0] pixel_port_lines,
  input wire logic [7:0] vga_port_lines,
  input wire logic shift_clock,
  input wire logic dot_rate_clock,
  input wire logic split_or_nibble_flag_input,
  output logic [7:0] palette_addr,
  output logic [23:0] dac_direct,
  output logic overlay_active,
  output ppmx_pkg::ppmx_kind_t pixel_kind,
  output logic pixel_valid,
  output logic [1:0] osc_select
);
  import ppmx_pkg::*;

  typedef struct packed
  {
    logic [7:0] mux_ctrl;
    logic [7:0] clk_sel;
    logic [7:0] gen_ctrl;
    logic [7:0] read_mask;
    logic [7:0] pal_page;
    logic [2:0] sclk_sync;
    logic [2:0] dot_sync;
    logic [2:0] flag_sync;
    logic sclk_seen;
    logic dot_seen;
    logic flag_seen;
    logic [31:0] cap;
    logic cap_full;
    logic [31:0] shreg;
    logic [5:0] left;
    logic [5:0] shreg_code;
    logic shreg_flag;
    ppmx_state_t state;
    logic [7:0] rdata;
    logic [7:0] pa;
    logic [23:0] dac;
    logic ovl;
    ppmx_kind_t kind;
    logic valid;
    logic [1:0] osc;
  } ppmx_regs_t;

  ppmx_regs_t r;
  ppmx_regs_t next_r;

  // ******************************
  // Helper functions
  // ******************************
  // Effective mode code, nibble mode first
  function automatic logic [5:0] eff_code(input logic [7:0] mux,
                                          input logic [7:0] gc);
    logic nib;
    nib = gc[`PPMX_GC_SNM] & ~gc[`PPMX_GC_SSRT];
    return nib ? `PPMX_MUX_NIBBLE : mux[`PPMX_MUX_CODE_W-1:0];
  endfunction

  // Groups per load from clock select
  function automatic logic [5:0] groups(input logic [7:0] cs);
    logic [2:0] sh;
    sh = cs[`PPMX_CS_SHIFT_LSB+2:`PPMX_CS_SHIFT_LSB];
    return (sh > 3'h5) ? 6'h01 : (6'h01 << sh);
  endfunction

  // Settled level of a three-stage synchroniser
  function automatic logic settle(input logic [2:0] s, input logic old);
    return (s[2] == s[1]) ? s[2] : old;
  endfunction

  // Group width in bits for a code
  function automatic logic [5:0] gwidth(input logic [5:0] code);
    logic [5:0] w;
    w = 6'h08;
    if (code == `PPMX_MUX_NIBBLE || code[5:2] == 4'b0110)
    begin
      w = 6'h04;
    end
    else if (code[5:3] == 3'b010)
    begin
      w = 6'h01 << code[2];
    end
    else if (code[5:3] == 3'b001)
    begin
      w = (code[2] == 1'b1) ? 6'h20 : 6'h10;
    end
    return w;
  endfunction

  // Pixel bits of the lowest group
  function automatic logic [31:0] low_group(input logic [31:0] s,
                                            input logic [5:0] code,
                                            input logic flag);
    if (code == `PPMX_MUX_NIBBLE)
    begin
      return {28'h0000000, (flag ? s[7:4] : s[3:0])};
    end
    return s & ((32'h00000001 << gwidth(code)) - 32'h00000001);
  endfunction

  // Shift register advance
  function automatic logic [31:0] advance(input logic [31:0] s,
                                          input logic [5:0] code);
    return (code == `PPMX_MUX_NIBBLE) ? (s >> 8) : (s >> gwidth(code));
  endfunction

  // ******************************
  // Next state
  // ******************************
  always_comb
  begin
    logic [5:0] code;
    logic [31:0] grp;
    logic pass;
    logic sclk_rise;
    logic dot_tick;
    code = eff_code(r.mux_ctrl, r.gen_ctrl);
    grp = 32'h00000000;
    pass = (code == `PPMX_MUX_PASS);
    sclk_rise = settle(r.sclk_sync, r.sclk_seen) & ~r.sclk_seen;
    dot_tick = settle(r.dot_sync, r.dot_seen) & ~r.dot_seen;
    next_r = r;
    next_r.rdata = 8'h00;
    next_r.valid = 1'b0;
    next_r.sclk_sync = {r.sclk_sync[1:0], shift_clock};
    next_r.dot_sync = {r.dot_sync[1:0], dot_rate_clock};
    next_r.flag_sync = {r.flag_sync[1:0], split_or_nibble_flag_input};
    next_r.sclk_seen = settle(r.sclk_sync, r.sclk_seen);
    next_r.dot_seen = settle(r.dot_sync, r.dot_seen);
    next_r.flag_seen = settle(r.flag_sync, r.flag_seen);
    // Register writes
    if (reg_wr)
    begin
      if (reg_addr == `PPMX_ADDR_MUX_CTRL)
      begin
        next_r.mux_ctrl = reg_wdata;
        if (reg_wdata[5:0] == `PPMX_MUX_PASS)
        begin
          next_r.clk_sel = `PPMX_RST_CLK_SEL;
          next_r.gen_ctrl = `PPMX_RST_GEN_CTRL;
          next_r.read_mask = `PPMX_RST_READ_MASK;
        end
      end
      else if (reg_addr == `PPMX_ADDR_CLK_SEL)
      begin
        next_r.clk_sel = reg_wdata;
      end
      else if (reg_addr == `PPMX_ADDR_GEN_CTRL)
      begin
        next_r.gen_ctrl = reg_wdata;
      end
      else if (reg_addr == `PPMX_ADDR_READ_MASK)
      begin
        next_r.read_mask = reg_wdata;
      end
      else if (reg_addr == `PPMX_ADDR_PAL_PAGE)
      begin
        next_r.pal_page = reg_wdata;
      end
    end
    // Register reads
    if (reg_rd)
    begin
      if (reg_addr == `PPMX_ADDR_MUX_CTRL)
      begin
        next_r.rdata = r.mux_ctrl;
      end
      else if (reg_addr == `PPMX_ADDR_CLK_SEL)
      begin
        next_r.rdata = r.clk_sel;
      end
      else if (reg_addr == `PPMX_ADDR_GEN_CTRL)
      begin
        next_r.rdata = r.gen_ctrl;
      end
      else if (reg_addr == `PPMX_ADDR_READ_MASK)
      begin
        next_r.rdata = r.read_mask;
      end
      else if (reg_addr == `PPMX_ADDR_PAL_PAGE)
      begin
        next_r.rdata = r.pal_page;
      end
      else if (reg_addr == `PPMX_ADDR_STATUS)
      begin
        next_r.rdata = {2'b00, r.left};
      end
    end
    next_r.osc = pass ? 2'b00 : r.clk_sel[`PPMX_CS_OSC_LSB+1:0];
    if (sclk_rise)
    begin
      next_r.cap = pass ? {24'h000000, vga_port_lines} : pixel_port_lines;
      next_r.cap_full = 1'b1;
    end
    case (r.state)
      PPMX_IDLE:
      begin
        next_r.state = r.cap_full ? PPMX_SHIFT : PPMX_IDLE;
      end
      PPMX_SHIFT:
      begin
        if (dot_tick)
        begin
          if (r.left == 6'h00)
          begin
            next_r.shreg = r.cap;
            next_r.shreg_code = code;
            next_r.shreg_flag = r.flag_seen;
            next_r.left = groups(r.clk_sel);
            next_r.cap_full = sclk_rise;
          end
          next_r.state = PPMX_PEND;
        end
      end
      PPMX_PEND:
      begin
        grp = low_group(r.shreg, r.shreg_code, r.shreg_flag);
        next_r.shreg = advance(r.shreg, r.shreg_code);
        next_r.left = r.left - 6'h01;
        next_r.valid = 1'b1;
        next_r.ovl = 1'b0;
        next_r.dac = 24'h000000;
        if (r.shreg_code[5:3] == 3'b001)
        begin
          next_r.kind = PPMX_KIND_TRUE;
          next_r.dac = grp[31:8];
          next_r.pa = grp[7:0] & r.read_mask;
          next_r.ovl = (next_r.pa != 8'h00);
        end
        else if (r.shreg_code == `PPMX_MUX_PASS)
        begin
          next_r.kind = PPMX_KIND_VGA;
          next_r.pa = grp[7:0] & r.read_mask;
        end
        else
        begin
          next_r.kind = PPMX_KIND_PAL;
          next_r.pa = (grp[7:0] | (r.pal_page &
                        ~((8'h01 << gwidth(r.shreg_code)) - 8'h01)))
                      & r.read_mask;
        end
        next_r.state = (next_r.left == 6'h00 && !r.cap_full) ?
                       PPMX_IDLE : PPMX_SHIFT;
      end
      default:
      begin
        next_r.state = PPMX_IDLE;
      end
    endcase
  end

  // ******************************
  // State register
  // ******************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r <= '0;
      r.mux_ctrl <= `PPMX_RST_MUX_CTRL;
      r.clk_sel <= `PPMX_RST_CLK_SEL;
      r.gen_ctrl <= `PPMX_RST_GEN_CTRL;
      r.read_mask <= `PPMX_RST_READ_MASK;
      r.pal_page <= `PPMX_RST_PAL_PAGE;
      r.state <= PPMX_IDLE;
      r.kind <= PPMX_KIND_VGA;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;
  assign palette_addr = r.pa;
  assign dac_direct = r.dac;
  assign overlay_active = r.ovl;
  assign pixel_kind = r.kind;
  assign pixel_valid = r.valid;
  assign osc_select = r.osc;
endmodule

// >>> tb.sv
// Testbench: registers and pixel serialisation of the multiplexer.
// Assumes design, package and source model compiled first.
`timescale 1ns/1ps
`include "ppmx_consts.svh"
module tb;
  import ppmx_pkg::*;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic flag = 1'h0;
  logic start = 1'h0;
  logic [31:0] word = 32'h0;
  logic [31:0] wm;
  logic [3:0] ngrp = 4'h1;
  logic [7:0] mask, page, reg_rdata, palette_addr, vga;
  logic [1:0] osc, osc_select;
  logic [23:0] dac_direct;
  logic [31:0] pix;
  logic overlay_active, pixel_valid, busy, sclk, dclk;
  ppmx_kind_t pixel_kind;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int gi = 0;
  int md = 0;
  int cd[11] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E,
    8'h1F, 8'h09, 8'h0E, 8'h2D};
  int lg[11] = '{0, 1, 2, 3, 0, 1, 2, 2, 2, 0, 0};
  int mt[11] = '{0, 0, 0, 0, 1, 1, 1, 2, 3, 4, 5};
  ppmx_top dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pixel_port_lines(pix), .vga_port_lines(vga),
    .shift_clock(sclk), .dot_rate_clock(dclk),
    .split_or_nibble_flag_input(flag), .palette_addr, .dac_direct,
    .overlay_active, .pixel_kind, .pixel_valid, .osc_select);
  ppmx_src src (.clk, .rst_b, .start, .word, .ngrp,
    .pixel_port_lines(pix), .vga_port_lines(vga), .shift_clock(sclk),
    .dot_rate_clock(dclk), .busy);
  initial
    forever #5 clk = ~clk;
  task automatic results();
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [3:0] a,
    input logic [7:0] d);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, r, a, d};
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'h0, 1'h1, a, 8'h00);
    #1;
    chk(32'(reg_rdata), 32'(e));
  endtask
  function automatic logic [7:0] exp_pa(int g);
    if (md == 1)
      return word[8 * g +: 8] & mask;
    if (md == 5)
      return word[15:8] & mask;
    if (md >= 2)
      return {page[7:4], word[8 * g + 4 * (md - 2) +: 4]} & mask;
    return {page[7:4], word[4 * g +: 4]} & mask;
  endfunction
  task automatic load();
    int k;
    bus(1'h0, 1'h0, 4'h0, 8'h00);
    word <= $urandom & wm;
    start <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
    gi = 0;
    @(posedge clk);
    for (k = 0; k < 300 && busy !== 1'h0; k++)
      @(posedge clk);
    chk(32'(gi), 32'(ngrp));
  endtask
  always @(negedge clk)
    if (pixel_valid === 1'h1)
    begin
      if (md == 4)
      begin
        chk(32'(dac_direct), 32'(word[31:8]));
        chk(32'(palette_addr), 32'(word[7:0] & mask));
        chk(32'(overlay_active), 32'(|(word[7:0] & mask)));
      end
      else
        chk(32'(palette_addr), 32'(exp_pa(gi)));
      chk(32'(pixel_kind), 32'(md == 5 ? PPMX_KIND_VGA : md == 4 ?
        PPMX_KIND_TRUE : PPMX_KIND_PAL));
      chk(32'(osc_select), 32'(md == 5 ? 2'h0 : osc));
      gi++;
    end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_total++;
      $display("unexpected %0t: timeout", $time);
      results();
    end
  end
  initial
  begin
    void'($urandom(32'h1D9F));
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rd(`PPMX_ADDR_MUX_CTRL, `PPMX_RST_MUX_CTRL);
    rd(`PPMX_ADDR_READ_MASK, `PPMX_RST_READ_MASK);
    rd(4'h9, 8'h00);
    bus(1'h1, 1'h0, `PPMX_ADDR_CLK_SEL, 8'h3B);
    bus(1'h1, 1'h0, `PPMX_ADDR_GEN_CTRL, 8'h04);
    bus(1'h1, 1'h0, `PPMX_ADDR_READ_MASK, 8'h5A);
    bus(1'h1, 1'h0, `PPMX_ADDR_MUX_CTRL, 8'hED);
    rd(`PPMX_ADDR_CLK_SEL, `PPMX_RST_CLK_SEL);
    rd(`PPMX_ADDR_READ_MASK, `PPMX_RST_READ_MASK);
    rd(`PPMX_ADDR_GEN_CTRL, `PPMX_RST_GEN_CTRL);
    for (int i = 0; i < 11; i++)
    begin
      md = mt[i];
      osc = 2'($urandom);
      page = {4'($urandom), 4'h0};
      wm = md == 0 ? 32'((64'h1 << (4 << lg[i])) - 1) :
        md == 1 ? 32'((64'h1 << (8 << lg[i])) - 1) : 32'hFFFFFFFF;
      ngrp <= 4'(1 << lg[i]);
      flag <= md == 3;
      bus(1'h1, 1'h0, 4'h0, {2'($urandom), 6'(cd[i])});
      bus(1'h1, 1'h0, 4'h1, {2'h0, 3'(lg[i]), 1'h0, osc});
      bus(1'h1, 1'h0, 4'h2, md == 3 ? 8'h08 : 8'h00);
      bus(1'h1, 1'h0, 4'h4, page);
      for (int j = 0; j < 2; j++)
      begin
        mask = md == 4 && j == 0 ? 8'h00 : 8'($urandom);
        bus(1'h1, 1'h0, 4'h3, mask);
        load();
      end
    end
    results();
  end
endmodule
